//--- pkg/hps_regs.svh
// Purpose: Register addresses, bit positions and timing counts of the host port.
// Assumes: Addresses are 8-bit host register addresses.
// Notes: Definitions only.
`ifndef HPS_REGS_SVH
`define HPS_REGS_SVH
`define HPS_ADDR_STAT_HI 8'h61
`define HPS_ADDR_STAT_LO 8'h62
`define HPS_ADDR_MSK3U 8'h63
`define HPS_ADDR_MSK3L 8'h64
`define HPS_ADDR_MEMDATA 8'h65
`define HPS_BIT_OVR2 11
`define HPS_BIT_PERR2 3
`define HPS_BIT_PERR1 2
`define HPS_BIT_UNLK2 1
`define HPS_BIT_UNLK1 0
`define HPS_BIT_SAX 7
`define HPS_BIT_SAM 6
`define HPS_BIT_DAX 5
`define HPS_BIT_DAM 4
`define HPS_BIT_PHYBD 1
`define HPS_BIT_AFBD 0
`define HPS_BIT_EMPTY2 14
`define HPS_BIT_FULL2 12
`define HPS_ZERO16 16'h0000
`define HPS_MASK_RST 16'hFFFF
`define HPS_EXEC_CNT 2'h1
`define HPS_HOLD_CNT 2'h2
`endif

//--- pkg/hps_pkg.sv
// Purpose: Types shared by the host port modules.
// Assumes: Nothing beyond the register header.
// Notes: States of the access sequencer.
package hps_pkg;
    typedef enum logic [2:0] {
        HPS_IDLE, HPS_EXEC, HPS_WAIT_MEM, HPS_DRIVE, HPS_HOLD
    } hps_state_t;
    typedef logic [15:0] hps_word_t;
endpackage

//--- pkg/hps_flag_if.sv
// Purpose: Carries event pulses and read-clear strobes to the status file.
// Assumes: Single clock.
// Notes: Upper and lower halves travel together.
`timescale 1ns/100ps
interface hps_flag_if;
    logic [15:0] set_hi;
    logic [15:0] set_lo;
    logic clr_hi;
    logic clr_lo;
    logic [15:0] level_hi;
    logic [15:0] stat_hi;
    logic [15:0] stat_lo;
    modport core (output set_hi, set_lo, clr_hi, clr_lo, level_hi,
        input stat_hi, stat_lo);
    modport file (input set_hi, set_lo, clr_hi, clr_lo, level_hi,
        output stat_hi, stat_lo);
endinterface

//--- hw/hps_status.sv
// Purpose: Sticky status bits of the third status register.
// Assumes: Clear strobes are single-cycle pulses from a host read.
// Notes: A set in the clear cycle wins so no event is lost.
`timescale 1ns/100ps
`include "hps_regs.svh"
module hps_status
    import hps_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    hps_flag_if.file fl
);
    logic [15:0] hi_q;
    logic [15:0] lo_q;

    // Events hold until the half is read or reset.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hi_q <= `HPS_ZERO16;
        end else if (fl.clr_hi) begin
            hi_q <= fl.set_hi;
        end else begin
            hi_q <= hi_q | fl.set_hi;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            lo_q <= `HPS_ZERO16;
        end else if (fl.clr_lo) begin
            lo_q <= fl.set_lo;
        end else begin
            lo_q <= lo_q | fl.set_lo;
        end
    end

    // Level bits follow the monitored conditions, never cleared by reads.
    assign fl.stat_hi = hi_q | fl.level_hi;
    assign fl.stat_lo = lo_q;
endmodule

//--- hw/hps_host_port.sv
// Behaviour
// - Set upper bit 11 when queue-2 FIFO overflows and data is lost.
// - Suppress frame-copied indicator on repeated frames while overflow bit set.
// - Upper bit 3 on queue-2 parity error, bit 2 on queue-1.
// - Upper bit 1 on queue-2 auto-unlock, bit 0 on queue-1.
// - Host reads draining past threshold clear the queue lock.
// - Lower bit 7 on exact source address filter match.
// - Lower bit 6 on any source address filter match.
// - Lower bit 5 on exact destination address filter match.
// - Lower bit 4 on any destination address filter match.
// - Lower bit 1 when physical layer self-test completes.
// - Lower bit 0 when address filter self-test completes.
// - Strobe ignored in synchronous mode; host holds it high.
// - Data bus not driven until a cycle after the sampling edge.
// - Read data valid with ready at second edge, held past deselect.
// - Ready low for exactly one cycle per access.
// - Registers take two cycles; memory data register may take longer.
// - Reading status clears set bits except buffer empty and full.
// - Each status bit may interrupt, gated by a mask register.
//
// Purpose: Synchronous host register port with the third status register.
// Assumes: Inputs synchronous to core_clk; bus clock is core_clk.
// Notes: Asynchronous mode is not handled here; with the strap low no access starts, and the strap is echoed on sync_mode.
`timescale 1ns/100ps
`include "hps_regs.svh"
module hps_host_port
    import hps_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic port_mode_sync,
    input wire logic chip_select_n,
    input wire logic [7:0] host_reg_address,
    input wire logic host_read_write,
    input wire logic host_strobe_n,
    input wire logic [15:0] host_data_bus_in,
    output logic [15:0] host_data_bus_out,
    output logic host_data_bus_oe_n,
    output logic ready_n,
    output logic mem_req,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output logic [15:0] mem_wdata,
    output logic mem_write,
    input wire logic q2_fifo_overflow,
    input wire logic q2_parity_error,
    input wire logic q1_parity_error,
    input wire logic q2_locked,
    input wire logic q1_locked,
    input wire logic q2_above_unlock,
    input wire logic q1_above_unlock,
    input wire logic q2_host_read,
    input wire logic q1_host_read,
    input wire logic q2_buffer_empty,
    input wire logic q2_buffer_full,
    input wire logic src_exact_match,
    input wire logic src_match,
    input wire logic dest_exact_match,
    input wire logic dest_match,
    input wire logic frame_repeated,
    input wire logic phy_selftest_done,
    input wire logic filter_selftest_done,
    output logic q2_unlock,
    output logic q1_unlock,
    output logic frame_copied_allow,
    output logic status_three_irq,
    output logic sync_mode
);
    hps_flag_if fl();
    hps_state_t state_q;
    logic [7:0] addr_q;
    logic rd_q;
    logic answer_now;
    logic [1:0] cnt_q;
    logic [15:0] mask_hi_q;
    logic [15:0] mask_lo_q;
    logic q2_unlock_ev;
    logic q1_unlock_ev;

    hps_status u_status (
        .core_clk(core_clk),
        .reset(reset),
        .fl(fl)
    );

    // One-hot position of a status bit; shared by both halves.
    function automatic logic [15:0] bit_at(input int pos);
        bit_at = 16'h0001 << pos;
    endfunction

    // Auto-unlock fires when a host read leaves a locked queue below
    // its threshold; the lock itself lives in the buffer manager.
    assign q2_unlock_ev = q2_locked & q2_host_read & ~q2_above_unlock;
    assign q1_unlock_ev = q1_locked & q1_host_read & ~q1_above_unlock;

    // Event pulses into the sticky status file.
    always_comb begin
        fl.set_hi = `HPS_ZERO16;
        fl.set_lo = `HPS_ZERO16;
        if (q2_fifo_overflow) begin
            fl.set_hi = fl.set_hi | bit_at(`HPS_BIT_OVR2);
        end
        if (q2_parity_error) begin
            fl.set_hi = fl.set_hi | bit_at(`HPS_BIT_PERR2);
        end
        if (q1_parity_error) begin
            fl.set_hi = fl.set_hi | bit_at(`HPS_BIT_PERR1);
        end
        if (q2_unlock_ev) begin
            fl.set_hi = fl.set_hi | bit_at(`HPS_BIT_UNLK2);
        end
        if (q1_unlock_ev) begin
            fl.set_hi = fl.set_hi | bit_at(`HPS_BIT_UNLK1);
        end
        if (src_exact_match) begin
            fl.set_lo = fl.set_lo | bit_at(`HPS_BIT_SAX);
        end
        if (src_match | src_exact_match) begin
            fl.set_lo = fl.set_lo | bit_at(`HPS_BIT_SAM);
        end
        if (dest_exact_match) begin
            fl.set_lo = fl.set_lo | bit_at(`HPS_BIT_DAX);
        end
        if (dest_match | dest_exact_match) begin
            fl.set_lo = fl.set_lo | bit_at(`HPS_BIT_DAM);
        end
        if (phy_selftest_done) begin
            fl.set_lo = fl.set_lo | bit_at(`HPS_BIT_PHYBD);
        end
        if (filter_selftest_done) begin
            fl.set_lo = fl.set_lo | bit_at(`HPS_BIT_AFBD);
        end
    end

    // Buffer empty and full are plain levels, never latched.
    assign fl.level_hi =
        (q2_buffer_empty ? bit_at(`HPS_BIT_EMPTY2) : `HPS_ZERO16)
        | (q2_buffer_full ? bit_at(`HPS_BIT_FULL2) : `HPS_ZERO16);

    // Read-clear strobes fire in the cycle the read data is captured.
    assign fl.clr_hi = (state_q == HPS_EXEC) && (cnt_q == `HPS_EXEC_CNT)
        && rd_q && (addr_q == `HPS_ADDR_STAT_HI);
    assign fl.clr_lo = (state_q == HPS_EXEC) && (cnt_q == `HPS_EXEC_CNT)
        && rd_q && (addr_q == `HPS_ADDR_STAT_LO);

    // The answer edge: end of a register execution, or memory done.
    assign answer_now = (state_q == HPS_EXEC && cnt_q == `HPS_EXEC_CNT
        && addr_q != `HPS_ADDR_MEMDATA)
        || (state_q == HPS_WAIT_MEM && mem_ack);

    // Access sequencer. The strobe input is never looked at here.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= HPS_IDLE;
            addr_q <= 8'h00;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            case (state_q)
                HPS_IDLE: begin
                    if (!chip_select_n && port_mode_sync) begin
                        addr_q <= host_reg_address;
                        rd_q <= host_read_write;
                        cnt_q <= 2'h0;
                        state_q <= HPS_EXEC;
                    end
                end
                HPS_EXEC: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (cnt_q == `HPS_EXEC_CNT) begin
                        if (addr_q == `HPS_ADDR_MEMDATA) begin
                            state_q <= HPS_WAIT_MEM;
                        end else begin
                            state_q <= HPS_DRIVE;
                        end
                    end
                end
                HPS_WAIT_MEM: begin
                    if (mem_ack) begin
                        state_q <= HPS_DRIVE;
                    end
                end
                HPS_DRIVE: begin
                    cnt_q <= 2'h0;
                    state_q <= HPS_HOLD;
                end
                HPS_HOLD: begin
                    if (chip_select_n) begin
                        cnt_q <= cnt_q + 2'h1;
                        if (cnt_q == `HPS_HOLD_CNT - 2'h1) begin
                            state_q <= HPS_IDLE;
                        end
                    end else begin
                        cnt_q <= 2'h0;
                    end
                end
                default: begin
                    state_q <= HPS_IDLE;
                end
            endcase
        end
    end

    // Ready pulses exactly once, at the edge that presents the answer.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ready_n <= 1'b1;
        end else begin
            ready_n <= !answer_now;
        end
    end

    // Read data is loaded at the answer edge so it stands with ready.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            host_data_bus_out <= `HPS_ZERO16;
        end else if (state_q == HPS_WAIT_MEM && mem_ack) begin
            host_data_bus_out <= mem_rdata;
        end else if (state_q == HPS_EXEC && cnt_q == `HPS_EXEC_CNT) begin
            if (addr_q == `HPS_ADDR_STAT_HI) begin
                host_data_bus_out <= fl.stat_hi;
            end else if (addr_q == `HPS_ADDR_STAT_LO) begin
                host_data_bus_out <= fl.stat_lo;
            end else if (addr_q == `HPS_ADDR_MSK3U) begin
                host_data_bus_out <= mask_hi_q;
            end else if (addr_q == `HPS_ADDR_MSK3L) begin
                host_data_bus_out <= mask_lo_q;
            end else begin
                host_data_bus_out <= `HPS_ZERO16;
            end
        end
    end

    // Bus turn-on waits a cycle after sampling so the last driver can
    // float; it stays on until two edges after select goes away.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            host_data_bus_oe_n <= 1'b1;
        end else begin
            host_data_bus_oe_n <= !(rd_q && (answer_now
                || state_q == HPS_DRIVE
                || (state_q == HPS_HOLD && !(chip_select_n
                && cnt_q == `HPS_HOLD_CNT - 2'h1))));
        end
    end

    // Interrupt mask, written at the end of a write execution.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mask_hi_q <= `HPS_MASK_RST;
            mask_lo_q <= `HPS_MASK_RST;
        end else if (state_q == HPS_EXEC && cnt_q == `HPS_EXEC_CNT
            && !rd_q) begin
            if (addr_q == `HPS_ADDR_MSK3U) begin
                mask_hi_q <= host_data_bus_in;
            end else if (addr_q == `HPS_ADDR_MSK3L) begin
                mask_lo_q <= host_data_bus_in;
            end
        end
    end

    // Memory data register access handshake.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_wdata <= `HPS_ZERO16;
        end else if (state_q == HPS_EXEC && cnt_q == `HPS_EXEC_CNT
            && addr_q == `HPS_ADDR_MEMDATA) begin
            mem_req <= 1'b1;
            mem_write <= !rd_q;
            mem_wdata <= host_data_bus_in;
        end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_write <= 1'b0;
        end
    end

    // Mask bit set means the source is blocked; reserved bits are left
    // to software, which must keep them masked.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            status_three_irq <= 1'b0;
        end else begin
            status_three_irq <= |(fl.stat_hi & ~mask_hi_q)
                | |(fl.stat_lo & ~mask_lo_q);
        end
    end

    // Side outputs: unlock pulses, copied-indicator gate, strap echo.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            q2_unlock <= 1'b0;
            q1_unlock <= 1'b0;
            frame_copied_allow <= 1'b1;
            sync_mode <= 1'b0;
        end else begin
            q2_unlock <= q2_unlock_ev;
            q1_unlock <= q1_unlock_ev;
            frame_copied_allow <= !(frame_repeated
                && fl.stat_hi[`HPS_BIT_OVR2]);
            sync_mode <= port_mode_sync;
        end
    end
endmodule

//--- tb/hps_host_port_properties.sv
// Purpose: Pin timing and side-effect checks of the host port.
// Assumes: Select stays high for several edges between accesses.
// Notes: Bound to the host port below.
`timescale 1ns/100ps
`include "hps_regs.svh"
module hps_host_port_properties (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic port_mode_sync,
    input wire logic chip_select_n,
    input wire logic [7:0] host_reg_address,
    input wire logic host_read_write,
    input wire logic host_data_bus_oe_n,
    input wire logic ready_n,
    input wire logic q2_fifo_overflow,
    input wire logic q2_locked,
    input wire logic q1_locked,
    input wire logic q2_above_unlock,
    input wire logic q1_above_unlock,
    input wire logic q2_host_read,
    input wire logic q1_host_read,
    input wire logic frame_copied_allow,
    input wire logic frame_repeated,
    input wire logic q2_unlock,
    input wire logic q1_unlock
);
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // An access starts only where the strap selects synchronous mode.
    sequence s_start;
        $fell(chip_select_n) && port_mode_sync;
    endsequence
    sequence s_reg_answer;
        ready_n [*3] ##1 !ready_n ##1 ready_n;
    endsequence
    // Read data outlives the select by one edge, then the bus is freed.
    sequence s_release;
        !host_data_bus_oe_n ##[1:2] host_data_bus_oe_n;
    endsequence
    a_reg_latency: assert property (
        s_start ##0 (host_reg_address != `HPS_ADDR_MEMDATA)
        |-> s_reg_answer)
        else $error("register access answered at the wrong edge");
    a_no_early_drive: assert property (
        s_start |-> host_data_bus_oe_n [*2])
        else $error("data bus driven too soon after select");
    a_ready_single: assert property (
        !ready_n |=> ready_n)
        else $error("ready held low for more than one cycle");
    a_read_drives: assert property (
        !ready_n && host_read_write |-> !host_data_bus_oe_n)
        else $error("read answered without driving the bus");
    a_read_hold: assert property (
        $rose(chip_select_n) && !host_data_bus_oe_n |-> ##1 s_release)
        else $error("read data not held or not released");
    a_overflow_copy: assert property (
        q2_fifo_overflow && frame_repeated ##1 frame_repeated
        |=> !frame_copied_allow)
        else $error("frame copied still allowed after overflow");
    a_q2_unlock: assert property (
        q2_locked && q2_host_read && !q2_above_unlock |=> q2_unlock)
        else $error("queue 2 lock not released");
    a_q1_unlock: assert property (
        q1_locked && q1_host_read && !q1_above_unlock |=> q1_unlock)
        else $error("queue 1 lock not released");
    a_async_ignored: assert property (
        (!port_mode_sync) [*4] |-> ready_n)
        else $error("access answered in asynchronous mode");
endmodule
bind hps_host_port hps_host_port_properties u_props (
    .core_clk, .reset, .port_mode_sync, .chip_select_n, .host_reg_address,
    .host_read_write, .host_data_bus_oe_n, .ready_n, .q2_fifo_overflow,
    .q2_locked, .q1_locked, .q2_above_unlock, .q1_above_unlock,
    .q2_host_read, .q1_host_read, .frame_copied_allow, .frame_repeated,
    .q2_unlock, .q1_unlock
);

//--- tb/hps_node_model.sv
// Purpose: Node processor making synchronous host port accesses.
// Assumes: Called just after a rising edge.
// Notes: A released bus shows the inverse of its last value.
`timescale 1ns/100ps
module hps_node_model (
    input wire logic core_clk,
    input wire logic ready_n,
    input wire logic [15:0] host_data_bus_out,
    input wire logic host_data_bus_oe_n,
    output logic chip_select_n,
    output logic [7:0] host_reg_address,
    output logic host_read_write,
    output logic host_strobe_n,
    output logic [15:0] host_data_bus_in
);
    logic [15:0] bus_last;
    // The strobe means nothing in synchronous mode and stays high.
    initial begin
        chip_select_n = 1'b1;
        host_reg_address = 8'h00;
        host_read_write = 1'b1;
        host_strobe_n = 1'b1;
        host_data_bus_in = 16'h0000;
        bus_last = 16'h0000;
    end
    // The request is held until ready is seen low, a bounded wait.
    task automatic access(input logic rd, input logic [7:0] addr,
        input logic [15:0] wdata, output logic [15:0] rdata);
        int n;
        n = 0;
        chip_select_n <= 1'b0;
        host_reg_address <= addr;
        host_read_write <= rd;
        host_data_bus_in <= rd ? ~bus_last : wdata;
        do begin
            @(posedge core_clk);
            n++;
        end while (ready_n !== 1'b0 && n < 40);
        rdata = host_data_bus_oe_n ? ~bus_last : host_data_bus_out;
        if (ready_n !== 1'b0) rdata = 16'hxxxx;
        bus_last = rd ? rdata : wdata;
        chip_select_n <= 1'b1;
        host_data_bus_in <= ~bus_last;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

//--- tb/testbench.sv
// Purpose: Self-checking bench of the host port and status register.
// Assumes: One clock; strap high except in the asynchronous test.
// Notes: A bit model of both status halves predicts every read.
`timescale 1ns/100ps
`include "hps_regs.svh"
module testbench;
    logic core_clk, reset, port_mode_sync, chip_select_n, host_read_write;
    logic host_strobe_n, host_data_bus_oe_n, ready_n, mem_req, mem_ack;
    logic mem_write, q2_fifo_overflow, q2_parity_error, q1_parity_error;
    logic q2_locked, q1_locked, q2_above_unlock, q1_above_unlock;
    logic q2_host_read, q1_host_read, q2_buffer_empty, q2_buffer_full;
    logic src_exact_match, src_match, dest_exact_match, dest_match;
    logic frame_repeated, phy_selftest_done, filter_selftest_done;
    logic q2_unlock, q1_unlock, frame_copied_allow, status_three_irq;
    logic sync_mode;
    logic [1:0] mem_cnt;
    logic [7:0] host_reg_address;
    logic [10:0] ev;
    logic [15:0] host_data_bus_in, host_data_bus_out, mem_rdata, mem_wdata;
    logic [15:0] exp_hi, exp_lo, msk_hi, msk_lo, rd;
    logic [16:0] mem_seen;
    int mismatches, samples_checked, cycles;
    hps_host_port uut (
        .core_clk, .reset, .port_mode_sync, .chip_select_n,
        .host_reg_address, .host_read_write, .host_strobe_n,
        .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe_n,
        .ready_n, .mem_req, .mem_ack, .mem_rdata, .mem_wdata, .mem_write,
        .q2_fifo_overflow, .q2_parity_error, .q1_parity_error, .q2_locked,
        .q1_locked, .q2_above_unlock, .q1_above_unlock, .q2_host_read,
        .q1_host_read, .q2_buffer_empty, .q2_buffer_full, .src_exact_match,
        .src_match, .dest_exact_match, .dest_match, .frame_repeated,
        .phy_selftest_done, .filter_selftest_done, .q2_unlock, .q1_unlock,
        .frame_copied_allow, .status_three_irq, .sync_mode
    );
    hps_node_model host (
        .core_clk, .ready_n, .host_data_bus_out, .host_data_bus_oe_n,
        .chip_select_n, .host_reg_address, .host_read_write,
        .host_strobe_n, .host_data_bus_in
    );
    // One source stands for both device clocks, so they stay in phase.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Memory answers late so that ready must wait; a hang is cut short.
    // The direction and data of each memory request are kept for checks.
    always @(posedge core_clk) begin
        if (reset) begin
            mem_ack <= 1'b0;
            mem_cnt <= 2'h0;
        end else begin
            mem_ack <= mem_req && !mem_ack && mem_cnt == 2'h3;
            mem_cnt <= (mem_req && !mem_ack) ? mem_cnt + 2'h1 : 2'h0;
        end
        if (mem_req && !mem_ack) begin
            mem_seen <= {mem_write, mem_wdata};
        end
        cycles <= cycles + 1;
        if (cycles > 4000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic check16(string name, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic check1(string name, logic e, logic g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", name, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Events last one cycle; a lock is released only on request.
    task automatic fire(input logic [10:0] e);
        q2_fifo_overflow <= e[0];
        q2_parity_error <= e[1];
        q1_parity_error <= e[2];
        q2_locked <= e[3] | e[1];
        q2_host_read <= e[3];
        q2_above_unlock <= ~e[3];
        q1_locked <= e[4] | e[2];
        q1_host_read <= e[4];
        q1_above_unlock <= ~e[4];
        src_exact_match <= e[5];
        src_match <= e[6];
        dest_exact_match <= e[7];
        dest_match <= e[8];
        phy_selftest_done <= e[9];
        filter_selftest_done <= e[10];
        @(posedge core_clk);
    endtask
    initial begin
        {reset, port_mode_sync, frame_repeated} = 3'h7;
        {q2_buffer_empty, q2_buffer_full} = 2'h0;
        {mem_rdata, exp_hi, exp_lo} = 48'h0000_0000_0000;
        {mismatches, samples_checked} = 64'h0;
        fire(11'h000);
        void'($urandom(91738));
        repeat (9) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        host.access(1'b1, `HPS_ADDR_MSK3U, 16'h0000, rd);
        check16("mask reset", `HPS_MASK_RST, rd);
        host.access(1'b1, `HPS_ADDR_STAT_LO, 16'h0000, rd);
        check16("lower reset", 16'h0000, rd & 16'h00F3);
        check1("copy reset", 1'b1, frame_copied_allow);
        check1("sync echo", 1'b1, sync_mode);
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            ev = 11'($urandom);
            msk_hi = 16'($urandom) | 16'hF7F0;
            msk_lo = 16'($urandom) | 16'hFF0C;
            q2_buffer_empty <= ev[1];
            q2_buffer_full <= ev[2];
            frame_repeated <= 1'($urandom);
            host.access(1'b0, `HPS_ADDR_MSK3U, msk_hi, rd);
            host.access(1'b0, `HPS_ADDR_MSK3L, msk_lo, rd);
            host.access(1'b1, `HPS_ADDR_MSK3U, 16'h0000, rd);
            check16("mask upper", msk_hi, rd);
            host.access(1'b1, `HPS_ADDR_MSK3L, 16'h0000, rd);
            check16("mask lower", msk_lo, rd);
            fire(ev);
            fire(11'h000);
            exp_hi = exp_hi | {4'h0, ev[0], 7'h00, ev[1], ev[2], ev[3],
                ev[4]};
            exp_lo = exp_lo | {8'h00, ev[5], ev[5] | ev[6], ev[7],
                ev[7] | ev[8], 2'h0, ev[9], ev[10]};
            repeat (2) @(posedge core_clk);
            check1("irq", |((exp_hi & ~msk_hi) | (exp_lo & ~msk_lo)),
                status_three_irq);
            check1("copy allow", ~(exp_hi[11] & frame_repeated),
                frame_copied_allow);
            host.access(1'b1, `HPS_ADDR_STAT_HI, 16'h0000, rd);
            check16("upper", exp_hi | {1'b0, ev[1], 1'b0, ev[2], 12'h000},
                rd & 16'h580F);
            host.access(1'b1, `HPS_ADDR_STAT_LO, 16'h0000, rd);
            check16("lower", exp_lo, rd & 16'h00F3);
            {exp_hi, exp_lo} = 32'h0000_0000;
            $display("status round %0d done", i);
        end
        host.access(1'b0, 8'h70, 16'hA5A5, rd);
        host.access(1'b1, 8'h70, 16'h0000, rd);
        check16("unmapped", 16'h0000, rd);
        mem_rdata <= 16'($urandom);
        @(posedge core_clk);
        host.access(1'b1, `HPS_ADDR_MEMDATA, 16'h0000, rd);
        check16("memory data", mem_rdata, rd);
        check1("memory read", 1'b0, mem_seen[16]);
        msk_hi = 16'($urandom);
        host.access(1'b0, `HPS_ADDR_MEMDATA, msk_hi, rd);
        check16("memory wdata", msk_hi, mem_seen[15:0]);
        check1("memory write", 1'b1, mem_seen[16]);
        $display("access test done");
        port_mode_sync <= 1'b0;
        @(posedge core_clk);
        host.chip_select_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        check1("async ready", 1'b1, ready_n);
        check1("sync echo", 1'b0, sync_mode);
        host.chip_select_n <= 1'b1;
        @(posedge core_clk);
        port_mode_sync <= 1'b1;
        repeat (3) @(posedge core_clk);
        $display("mode test done");
        finish_test();
    end
endmodule
